// File: design/pcrb_pkg.sv
// Constants for the paged configuration register bank.
// Assumes one 25 MHz register clock and an I2C slave front end.
`default_nettype none
package pcrb_pkg;
    localparam logic [6:0] I2C_ADDR = 7'h18;
    localparam int PAGE_REGS = 128;
    // Page 0 register offsets
    localparam logic [6:0] REG_PAGE = 7'h00;
    localparam logic [6:0] REG_SRST = 7'h01;
    localparam logic [6:0] REG_RSV2 = 7'h02;
    localparam logic [6:0] REG_OTS = 7'h03;
    localparam logic [6:0] REG_CMUX = 7'h04;
    localparam logic [6:0] REG_PLLPR = 7'h05;
    localparam logic [6:0] REG_PLLJ = 7'h06;
    localparam logic [6:0] REG_DMSB = 7'h07;
    localparam logic [6:0] REG_DLSB = 7'h08;
    // Page 3 master-clock divider register
    localparam logic [6:0] REG_MDIV = 7'h10;
    // Defined pages
    localparam logic [7:0] PG0 = 8'h00;
    localparam logic [7:0] PG1 = 8'h01;
    localparam logic [7:0] PG3 = 8'h03;
    localparam logic [7:0] PG_BUFA0 = 8'h08;
    localparam logic [7:0] PG_BUFA1 = 8'h09;
    localparam logic [7:0] PG_BUFB0 = 8'h0c;
    localparam logic [7:0] PG_BUFB1 = 8'h0d;
    // Reset values
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_CMUX = 8'h00;
    localparam logic [7:0] RST_PLLPR = 8'h11;
    localparam logic [7:0] RST_PLLJ = 8'h04;
    localparam logic [7:0] RST_DMSB = 8'h00;
    localparam logic [7:0] RST_DLSB = 8'h00;
    localparam logic [7:0] RST_MDIV = 8'h01;
    localparam logic [7:0] RST_COEF = 8'h00;
    // Field positions and masks
    localparam int SRST_BIT = 0;
    localparam int OT_BIT = 1;
    localparam int PLL_PWR_BIT = 7;
    localparam logic [7:0] CMUX_MASK = 8'h0f;
    localparam logic [7:0] J_MASK = 8'h3f;
    localparam logic [7:0] DMSB_MASK = 8'h3f;
    localparam logic [7:0] OT_RSVD = 8'hfc;
    // Coefficient store: 4 pages of 128 bytes
    localparam int COEF_WORDS = 512;
endpackage
`default_nettype wire

// File: design/pcrb_i2c_slave.sv
// Byte-level I2C slave: start/stop detect, address match, byte shift.
// Assumes scl and sda inputs are already synchronised to ref_clk.
`default_nettype none
module pcrb_i2c_slave
    import pcrb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Synchronised bus lines
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    // Byte side
    output logic wr_stb,
    output logic first_byte,
    output logic [7:0] wr_data,
    output logic rd_stb,
    input wire logic [7:0] rd_data,
    output logic bus_stop
);
    typedef enum {IDLE, ADDR, WDATA, RDATA, ACK, RACK, SKIP} pcrb_st_t;
    pcrb_st_t st;
    pcrb_st_t after;
    logic scl_d, sda_d;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic first;
    logic start_c, stop_c, rise, fall;

    assign start_c = scl && scl_d && sda_d && !sda;
    assign stop_c = scl && scl_d && !sda_d && sda;
    assign rise = scl && !scl_d;
    assign fall = !scl && scl_d;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // ==========================================================
    // Bit and byte sequencing
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= IDLE;
            after <= IDLE;
            sh <= 8'h00;
            cnt <= 4'h0;
            first <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            first_byte <= 1'b0;
            wr_data <= 8'h00;
            bus_stop <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            bus_stop <= stop_c;
            if (start_c) begin
                st <= ADDR;
                cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                st <= IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st)
                    IDLE: sda_oe <= 1'b0;
                    ADDR, WDATA: begin
                        if (rise) begin
                            sh <= {sh[6:0], sda};
                            cnt <= cnt + 4'h1;
                        end
                        if (fall && cnt == 4'h8) begin
                            cnt <= 4'h0;
                            if (st == ADDR) begin
                                if (sh[7:1] == I2C_ADDR) begin
                                    first <= 1'b1;
                                    sda_oe <= 1'b1;
                                    // Pointer already names the first byte
                                    after <= sh[0] ? RDATA : WDATA;
                                    st <= ACK;
                                end else begin
                                    st <= SKIP;
                                end
                            end else begin
                                wr_stb <= 1'b1;
                                wr_data <= sh;
                                first_byte <= first;
                                first <= 1'b0;
                                sda_oe <= 1'b1;
                                after <= WDATA;
                                st <= ACK;
                            end
                        end
                    end
                    ACK: begin
                        if (fall) begin
                            st <= after;
                            cnt <= 4'h0;
                            sda_oe <= (after == RDATA) ? !rd_data[7] : 1'b0;
                            sh <= rd_data;
                        end
                    end
                    RDATA: begin
                        if (fall) begin
                            cnt <= cnt + 4'h1;
                            if (cnt == 4'h7) begin
                                sda_oe <= 1'b0;
                                st <= RACK;
                            end else begin
                                sh <= {sh[6:0], 1'b0};
                                sda_oe <= !sh[6];
                            end
                        end
                    end
                    RACK: begin
                        if (rise) begin
                            // Master ack fetches the next register
                            if (!sda) begin
                                rd_stb <= 1'b1;
                                after <= RDATA;
                                st <= ACK;
                            end else begin
                                st <= SKIP;
                            end
                        end
                    end
                    SKIP: sda_oe <= 1'b0;
                    default: st <= IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: design/pcrb_regbank.sv
// Paged configuration register bank behind an I2C slave port.
// Assumes scl/sda come from pins; sda is open drain via sda_oe.
`default_nettype none
// What this block does
// - Pages of 8-bit registers, 128 each
// - Register 0 write selects current page
// - Page 0 selected after any reset
// - Writable registers read back; status read-only
// - Coefficient buffers A pages 8-9, B 12-13
// - Page 3 register 16 sets clock divider
// - Register 1 bit 0 resets, self-clears
// - Register 3 bit 1 low on overtemperature
// - Register 4 bits 3-2 pick PLL reference
// - Register 4 bits 1-0 pick converter clock
// - Register 5 bit 7 powers PLL
// - Pre-divider bits 6-4, code 0 means 8
// - Multiplier R bits 3-0, code 0 means 16
// - J field 0 to 63, resets to 4
// - D high bits apply when register 8 follows
// - Register 8 low D bits, written after 7
// - Write bytes auto-increment register address
// - Acked read sends next register
// - Respond only at slave address 0x18
module pcrb_regbank
    import pcrb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Status input from the speaker amplifier
    input wire logic overtemp_n,
    // Clock configuration outputs
    output logic [1:0] pll_ref_input,
    output logic [1:0] converter_clock_source,
    output logic pll_power,
    output logic [3:0] pll_p_div,
    output logic [4:0] pll_r_mult,
    output logic [5:0] pll_j_mult,
    output logic [13:0] pll_d_frac,
    output logic [7:0] mclk_div
);
    // Synchronised pins
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic ot_m;
    logic ot_s;

    // Byte interface to the slave
    logic wr_stb;
    logic first_byte;
    logic rd_stb;
    logic oe_i;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    // Pointer and register state
    logic [7:0] page;
    logic [6:0] addr;
    logic [7:0] cmux;
    logic [7:0] pllpr;
    logic [7:0] pllj;
    logic [7:0] dmsb_stage;
    logic [7:0] dmsb;
    logic [7:0] dlsb;
    logic [7:0] mdiv;
    logic d_armed;
    logic soft_rst;

    // Page 1 and coefficient storage
    logic [7:0] coef [COEF_WORDS];
    logic [7:0] pg1 [PAGE_REGS];

    // ==========================================================
    // Pin synchronisers
    // Idle-high reset levels keep a false START away after reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
        end
    end

    // Overtemperature level reads as normal until it is seen
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ot_m <= 1'b1;
            ot_s <= 1'b1;
        end else begin
            ot_m <= overtemp_n;
            ot_s <= ot_m;
        end
    end

    pcrb_i2c_slave u_slave (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .scl(scl_s),
        .sda(sda_s),
        .sda_oe(oe_i),
        .wr_stb(wr_stb),
        .first_byte(first_byte),
        .wr_data(wr_data),
        .rd_stb(rd_stb),
        .rd_data(rd_data),
        .bus_stop()
    );

    // ==========================================================
    // Address decode helpers
    // Pages outside the buffers map to slot 0 but never write
    function automatic logic [1:0] coef_page(input logic [7:0] p);
        case (p)
            PG_BUFA0: coef_page = 2'd0;
            PG_BUFA1: coef_page = 2'd1;
            PG_BUFB0: coef_page = 2'd2;
            PG_BUFB1: coef_page = 2'd3;
            default: coef_page = 2'd0;
        endcase
    endfunction

    function automatic logic is_coef(input logic [7:0] p);
        is_coef = (p == PG_BUFA0) || (p == PG_BUFA1) ||
                  (p == PG_BUFB0) || (p == PG_BUFB1);
    endfunction

    logic data_wr;
    logic [8:0] coef_idx;
    assign data_wr = wr_stb && !first_byte;
    assign coef_idx = {coef_page(page), addr};

    // ==========================================================
    // Register pointer: first byte sets it, later bytes advance it
    // Seven bits wide, so it wraps from 127 back to 0
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            addr <= 7'h00;
        end else if (wr_stb && first_byte) begin
            addr <= wr_data[6:0];
        end else if (data_wr || rd_stb) begin
            addr <= addr + 7'h01;
        end
    end

    // ==========================================================
    // Page selector; any page's register 0 writes it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            page <= RST_PAGE;
        end else if (soft_rst) begin
            page <= RST_PAGE;
        end else if (data_wr && addr == REG_PAGE) begin
            page <= wr_data;
        end
    end

    // Self-clearing: pulses for one cycle only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= data_wr && page == PG0 && addr == REG_SRST &&
                        wr_data[SRST_BIT];
        end
    end

    // ==========================================================
    // Page 0 clock and PLL registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmux <= RST_CMUX;
            pllpr <= RST_PLLPR;
            pllj <= RST_PLLJ;
        end else if (soft_rst) begin
            cmux <= RST_CMUX;
            pllpr <= RST_PLLPR;
            pllj <= RST_PLLJ;
        end else if (data_wr && page == PG0) begin
            // Reserved bits are masked so they read back as zero
            if (addr == REG_CMUX) begin
                cmux <= wr_data & CMUX_MASK;
            end
            if (addr == REG_PLLPR) begin
                pllpr <= wr_data;
            end
            if (addr == REG_PLLJ) begin
                pllj <= wr_data & J_MASK;
            end
        end
    end

    // D high byte is staged and applied only by a following LSB write
    // Reading register 7 shows the staged half
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dmsb_stage <= RST_DMSB;
            dmsb <= RST_DMSB;
            dlsb <= RST_DLSB;
            d_armed <= 1'b0;
        end else if (soft_rst) begin
            dmsb_stage <= RST_DMSB;
            dmsb <= RST_DMSB;
            dlsb <= RST_DLSB;
            d_armed <= 1'b0;
        end else if (data_wr) begin
            // Any other data byte, on any page, disarms the stage
            d_armed <= page == PG0 && addr == REG_DMSB;
            if (page == PG0 && addr == REG_DMSB) begin
                dmsb_stage <= wr_data & DMSB_MASK;
            end
            if (page == PG0 && addr == REG_DLSB) begin
                dlsb <= wr_data;
                if (d_armed)
                    dmsb <= dmsb_stage;
            end
        end
    end

    // ==========================================================
    // Page 3 divider, page 1 bank and coefficient buffers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mdiv <= RST_MDIV;
        end else if (soft_rst) begin
            mdiv <= RST_MDIV;
        end else if (data_wr && page == PG3 && addr == REG_MDIV) begin
            mdiv <= wr_data;
        end
    end

    // Flip-flop store is costly but keeps one clock and no macro
    genvar gi;
    generate
        for (gi = 0; gi < COEF_WORDS; gi++) begin : g_coef
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    coef[gi] <= RST_COEF;
                end else if (soft_rst) begin
                    coef[gi] <= RST_COEF;
                end else if (data_wr && is_coef(page) && addr != REG_PAGE &&
                             coef_idx == 9'(gi)) begin
                    coef[gi] <= wr_data;
                end
            end
        end

        // Register 0 of page 1 is the page selector, not a byte here
        for (gi = 0; gi < PAGE_REGS; gi++) begin : g_pg1
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    pg1[gi] <= 8'h00;
                end else if (soft_rst) begin
                    pg1[gi] <= 8'h00;
                end else if (data_wr && page == PG1 && addr != REG_PAGE &&
                             addr == 7'(gi)) begin
                    pg1[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read-back mux; status registers ignore writes
    // Unused pages and reserved registers read as zero, except register 0, which reads the page on every page
    always_comb begin
        rd_data = 8'h00;
        if (addr == REG_PAGE) begin
            rd_data = page;
        end else if (page == PG0) begin
            case (addr)
                REG_OTS: rd_data = {6'h00, ot_s, 1'b0};
                REG_CMUX: rd_data = cmux;
                REG_PLLPR: rd_data = pllpr;
                REG_PLLJ: rd_data = pllj;
                REG_DMSB: rd_data = dmsb_stage;
                REG_DLSB: rd_data = dlsb;
                default: rd_data = 8'h00;
            endcase
        end else if (page == PG1) begin
            rd_data = pg1[addr];
        end else if (page == PG3) begin
            rd_data = (addr == REG_MDIV) ? mdiv : 8'h00;
        end else if (is_coef(page)) begin
            rd_data = coef[coef_idx];
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pll_ref_input <= 2'b00;
            converter_clock_source <= 2'b00;
        end else begin
            pll_ref_input <= cmux[3:2];
            converter_clock_source <= cmux[1:0];
        end
    end

    // P and R codes of zero stand for the top divide and multiply values
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pll_power <= 1'b0;
            pll_p_div <= 4'h1;
            pll_r_mult <= 5'h01;
            pll_j_mult <= 6'h04;
            pll_d_frac <= 14'h0000;
        end else begin
            pll_power <= pllpr[PLL_PWR_BIT];
            pll_p_div <= (pllpr[6:4] == 3'b000) ? 4'h8
                         : {1'b0, pllpr[6:4]};
            pll_r_mult <= (pllpr[3:0] == 4'h0) ? 5'h10
                          : {1'b0, pllpr[3:0]};
            pll_j_mult <= pllj[5:0];
            pll_d_frac <= {dmsb[5:0], dlsb};
        end
    end

    // Open drain: the pin is only ever pulled low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mclk_div <= RST_MDIV;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            mclk_div <= mdiv;
            sda_oe <= oe_i;
            sda_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: test/pcrb_i2c_master.sv
// I2C bus master model that drives the register bank's bus pins.
// Assumes a pull-up on SDA and a testbench that ties the lines together.
`default_nettype none
module pcrb_i2c_master (
    // Clock
    input wire logic ref_clk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // =====================================
    // Bus phases
    // Data moves only mid-low, well past the slave's synchroniser delay
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic start();
        tick(5);
        sda_pull = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(10);
        sda_pull = 1'b1;
        tick(10);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(5);
        sda_pull = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(10);
        sda_pull = 1'b0;
        tick(10);
    endtask
    // Nine bits out, nine sampled; a one releases the line
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            tick(5);
            sda_pull = !tx[i];
            tick(5);
            scl = 1'b1;
            tick(5);
            rx[i] = sda;
            tick(5);
            scl = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: test/pcrb_regbank_asserts.sv
// Checker for the register bank, watching its top-level ports only.
// Assumes one ref_clk domain with rstn as asynchronous active-low reset.
`default_nettype none
module pcrb_regbank_asserts
    import pcrb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Status
    input wire logic overtemp_n,
    // Clock configuration
    input wire logic [1:0] pll_ref_input,
    input wire logic [1:0] converter_clock_source,
    input wire logic pll_power,
    input wire logic [3:0] pll_p_div,
    input wire logic [4:0] pll_r_mult,
    input wire logic [5:0] pll_j_mult,
    input wire logic [13:0] pll_d_frac,
    input wire logic [7:0] mclk_div
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // =====================================
    // Properties
    a_open_drain: assert property (
        sda_out == 1'b0) else $error("sda driven high");
    a_reset_values: assert property (
        $rose(rstn) |-> pll_p_div == 4'h1 && pll_r_mult == 5'h01 &&
        pll_j_mult == 6'h04 && mclk_div == RST_MDIV && !pll_power)
        else $error("bad values after reset");
    a_pdiv_range: assert property (
        pll_p_div inside {[1:8]}) else $error("pre-divider out of range");
    a_rmult_range: assert property (
        pll_r_mult inside {[1:16]}) else $error("R out of range");
    // Changing SDA while SCL is high would read as START or STOP
    a_oe_scl_low: assert property (
        $changed(sda_oe) |-> !scl_in && $past(scl_in) == 1'b0)
        else $error("sda changed with scl high");
    a_power_at_ack: assert property (
        $changed(pll_power) |-> ##[0:30] sda_oe)
        else $error("power moved outside a write");
    a_frac_at_ack: assert property (
        $changed(pll_d_frac) |-> ##[0:30] sda_oe)
        else $error("fraction moved outside a write");
    a_mclk_at_ack: assert property (
        $changed(mclk_div) |-> ##[0:30] sda_oe)
        else $error("divider moved outside a write");
endmodule
bind pcrb_regbank pcrb_regbank_asserts u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .overtemp_n(overtemp_n),
    .pll_ref_input(pll_ref_input),
    .converter_clock_source(converter_clock_source),
    .pll_power(pll_power), .pll_p_div(pll_p_div), .pll_r_mult(pll_r_mult),
    .pll_j_mult(pll_j_mult), .pll_d_frac(pll_d_frac), .mclk_div(mclk_div)
);
`default_nettype wire

// File: test/testbench.sv
// Self-checking testbench for the register bank over its I2C port.
// Assumes the master model and a pull-up resolving the SDA wire.
`default_nettype none
module testbench import pcrb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    wire scl;
    wire sda;
    logic ref_clk, rstn, overtemp_n, sda_pull, sda_out, sda_oe, pll_power;
    logic [1:0] pll_ref_input, converter_clock_source;
    logic [3:0] pll_p_div;
    logic [4:0] pll_r_mult;
    logic [5:0] pll_j_mult;
    logic [13:0] pll_d_frac;
    logic [7:0] mclk_div;
    logic [7:0] rb [0:8];
    logic [8:0] rx;
    int n_errors, n_tests;
    assign sda = !(sda_pull || sda_oe);
    pcrb_i2c_master master (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_pull(sda_pull));
    pcrb_regbank i_pcrb_regbank (.ref_clk(ref_clk), .rstn(rstn),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .overtemp_n(overtemp_n), .pll_ref_input(pll_ref_input),
        .converter_clock_source(converter_clock_source),
        .pll_power(pll_power), .pll_p_div(pll_p_div),
        .pll_r_mult(pll_r_mult), .pll_j_mult(pll_j_mult),
        .pll_d_frac(pll_d_frac), .mclk_div(mclk_div));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // =====================================
    // Shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic ack);
        master.xfer({b, 1'b1}, rx);
        check(rx[0], !ack);
    endtask
    // Reserved bits are always written as zero
    task automatic wr(input logic [7:0] r, a, b, input int n);
        master.start();
        send({I2C_ADDR, 1'b0}, 1'b1);
        send(r, 1'b1);
        send(a, 1'b1);
        if (n > 1) send(b, 1'b1);
        master.stop();
    endtask
    task automatic rd(input logic [7:0] r, input int n);
        master.start();
        send({I2C_ADDR, 1'b0}, 1'b1);
        send(r, 1'b1);
        master.start();
        send({I2C_ADDR, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            master.xfer({8'hff, i == n - 1}, rx);
            rb[i] = rx[8:1];
        end
        master.stop();
    endtask
    task automatic chk_rst();
        check(pll_p_div, 4'h1);
        check(pll_r_mult, 5'h01);
        check(pll_j_mult, 6'h04);
        check(mclk_div, RST_MDIV);
        check(pll_power, 1'b0);
        check(pll_d_frac, 14'h0000);
    endtask
    // =====================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] e [0:8];
        e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h04, 8'h00, 8'h00};
        chk_rst();
        rd(8'h00, 9);
        for (int i = 0; i < 9; i++) begin
            if (i == 3) check(rb[3][1], 1'b1);
            else check(rb[i], e[i]);
        end
    endtask
    task automatic t_pll();
        wr(8'h05, 8'h00, 8'h00, 1);
        check(pll_p_div, 4'h8);
        check(pll_r_mult, 5'h10);
        wr(8'h05, 8'hf7, 8'h00, 1);
        check({pll_power, pll_p_div, pll_r_mult}, 10'h2e7);
        wr(8'h06, 8'h3f, 8'h00, 1);
        check(pll_j_mult, 6'h3f);
        rd(8'h05, 2);
        check({rb[0], rb[1]}, 16'hf73f);
    endtask
    task automatic t_mux();
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, {4'h0, k[1:0], ~k[1:0]}, 8'h00, 1);
            check(pll_ref_input, k[1:0]);
            check(converter_clock_source, 2'(~k[1:0]));
        end
    endtask
    // High fraction bits only take effect with a following low byte
    task automatic t_frac();
        wr(8'h07, 8'h2a, 8'h00, 1);
        check(pll_d_frac, 14'h0000);
        wr(8'h07, 8'h15, 8'hc3, 2);
        check(pll_d_frac, 14'h15c3);
        wr(8'h08, 8'h5a, 8'h00, 1);
        check(pll_d_frac, 14'h155a);
    endtask
    task automatic t_ro();
        overtemp_n = 1'b0;
        wr(8'h03, 8'h00, 8'h00, 1);
        rd(8'h03, 1);
        check(rb[0][1], 1'b0);
        overtemp_n = 1'b1;
        rd(8'h03, 1);
        check(rb[0][1], 1'b1);
    endtask
    task automatic t_page();
        wr(8'h00, 8'h03, 8'h00, 1);
        wr(8'h10, 8'h05, 8'h00, 1);
        check(mclk_div, 8'h05);
        rd(8'h00, 1);
        check(rb[0], 8'h03);
        wr(8'h00, PG_BUFB0, 8'h00, 1);
        wr(8'h10, 8'h9c, 8'h00, 1);
        rd(8'h10, 1);
        check(rb[0], 8'h9c);
        wr(8'h00, 8'h00, 8'h00, 1);
        wr(8'h01, 8'h01, 8'h00, 1);
        chk_rst();
        rd(8'h00, 2);
        check({rb[0], rb[1]}, 16'h0000);
    endtask
    task automatic t_addr();
        master.start();
        send({I2C_ADDR ^ 7'h01, 1'b0}, 1'b0);
        send(8'h05, 1'b0);
        send(8'h80, 1'b0);
        master.stop();
        check(pll_power, 1'b0);
    endtask
    // =====================================
    // Run control
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        n_errors = 0;
        n_tests = 0;
        rstn = 1'b0;
        overtemp_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_pll();
        t_mux();
        t_frac();
        t_ro();
        t_page();
        t_addr();
        complete_run();
    end
    // Full run takes about 18.5k cycles
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
